/* File: src/hds_dc_servo_regs.sv */
/*
 Headphone DC servo register bank with a per-channel servo sequencer,
 periodic update timer and left headphone stage enables.
 Assumes an upstream serial-control slave on sys_clk delivering one-cycle
 register write/read strobes, and offset measurements on sys_clk.
*/
// How it works
// - Seven-bit series count, n+1 updates per series
// - Periodic updates every 0.256 s times 2^period, none at period 0
// - Right written offset, bits 15:8, two's complement
// - Left written offset, bits 7:0, two's complement
// - Combined done field: write or startup done
// - Write-mode done flags, bits 5:4
// - Startup-mode done flags, bits 1:0
// - Right applied offset readback, bits 7:0
// - Left applied offset readback, bits 7:0
// - Bit 7 removes left output short
// - Bit 6 enables left output stage
// - Bit 5 enables left intermediate stage
// - Write-mode trigger starts, reads busy
// - Startup trigger starts, reads busy
// - Series trigger runs configured update series
`timescale 1ns/100ps
module hds_dc_servo_regs
    import hds_pkg::*;
#(
    parameter int TICK_CYCLES    = hds_pkg::TICK_CYCLES_DOC,
    parameter int UPDATE_CYCLES  = hds_pkg::UPDATE_CYCLES_DEF,
    parameter int STARTUP_CYCLES = hds_pkg::STARTUP_CYCLES_DEF
)
(
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [hds_pkg::REG_AW-1:0]    reg_addr,
    input  wire logic [hds_pkg::REG_DW-1:0]    reg_wdata,
    output logic      [hds_pkg::REG_DW-1:0]    reg_rdata,
    output logic                               reg_rdata_valid,
    input  wire logic [hds_pkg::OFS_W-1:0]     left_measured_offset,
    input  wire logic [hds_pkg::OFS_W-1:0]     right_measured_offset,
    output logic      [hds_pkg::OFS_W-1:0]     left_applied_offset,
    output logic      [hds_pkg::OFS_W-1:0]     right_applied_offset,
    output logic                               left_short_removal,
    output logic                               left_output_stage_on,
    output logic                               left_intermediate_stage_on
);
    import hds_pkg::*;

    function automatic logic wr_hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] t);
        wr_hit = reg_wr && (a == t);
    endfunction

    // Configuration registers
    logic [6:0]       series_update_count_q, series_update_count_d;
    logic [3:0]       periodic_update_interval_q, periodic_update_interval_d;
    logic [OFS_W-1:0] right_written_offset_q, right_written_offset_d;
    logic [OFS_W-1:0] left_written_offset_q, left_written_offset_d;
    logic             short_rmv_q, short_rmv_d;
    logic             out_stage_q, out_stage_d;
    logic             mid_stage_q, mid_stage_d;
    logic             trig_wr, series_wr;

    always_comb
    begin
        trig_wr = wr_hit(reg_addr, ADDR_TRIGGER);
        series_wr = wr_hit(reg_addr, ADDR_SERIES);
        series_update_count_d = series_update_count_q;
        periodic_update_interval_d = periodic_update_interval_q;
        right_written_offset_d = right_written_offset_q;
        left_written_offset_d = left_written_offset_q;
        short_rmv_d = short_rmv_q;
        out_stage_d = out_stage_q;
        mid_stage_d = mid_stage_q;
        if (series_wr)
        begin
            series_update_count_d = reg_wdata[POS_SERIES_LO +: 7];
            periodic_update_interval_d = reg_wdata[POS_PERIOD_LO +: 4];
        end
        if (wr_hit(reg_addr, ADDR_WRITE_OFS))
        begin
            right_written_offset_d = reg_wdata[POS_RIGHT_WR_LO +: OFS_W];
            left_written_offset_d = reg_wdata[POS_LEFT_WR_LO +: OFS_W];
        end
        if (wr_hit(reg_addr, ADDR_HP_ENABLES))
        begin
            short_rmv_d = reg_wdata[POS_SHORT_RMV];
            out_stage_d = reg_wdata[POS_OUT_STAGE];
            mid_stage_d = reg_wdata[POS_MID_STAGE];
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            series_update_count_q <= SERIES_RESET;
            periodic_update_interval_q <= PERIOD_RESET;
            right_written_offset_q <= OFS_RESET;
            left_written_offset_q <= OFS_RESET;
            short_rmv_q <= 1'b0;
            out_stage_q <= 1'b0;
            mid_stage_q <= 1'b0;
        end
        else
        begin
            series_update_count_q <= series_update_count_d;
            periodic_update_interval_q <= periodic_update_interval_d;
            right_written_offset_q <= right_written_offset_d;
            left_written_offset_q <= left_written_offset_d;
            short_rmv_q <= short_rmv_d;
            out_stage_q <= out_stage_d;
            mid_stage_q <= mid_stage_d;
        end
    end

    assign left_short_removal = short_rmv_q;
    assign left_output_stage_on = out_stage_q;
    assign left_intermediate_stage_on = mid_stage_q;

    // Periodic timer: base tick of 0.256 s, then 2^period ticks; held clear at period 0
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic [PER_W-1:0]  per_cnt_q, per_cnt_d;
    logic [PER_W-1:0]  per_last;
    logic              periodic_q, periodic_d;

    always_comb
    begin
        per_last = PER_W'((PER_W'(1) << periodic_update_interval_q) - PER_W'(1));
        tick_cnt_d = tick_cnt_q;
        per_cnt_d = per_cnt_q;
        periodic_d = 1'b0;
        if (series_wr || periodic_update_interval_q == PERIOD_OFF)
        begin
            tick_cnt_d = '0;
            per_cnt_d = '0;
        end
        else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = '0;
            if (per_cnt_q == per_last)
            begin
                per_cnt_d = '0;
                periodic_d = 1'b1;
            end
            else
                per_cnt_d = PER_W'(per_cnt_q + PER_W'(1));
        end
        else
            tick_cnt_d = TICK_W'(tick_cnt_q + TICK_W'(1));
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tick_cnt_q <= '0;
            per_cnt_q <= '0;
            periodic_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            per_cnt_q <= per_cnt_d;
            periodic_q <= periodic_d;
        end
    end

    // Per-channel servo sequencers, index 0 left, 1 right
    logic [1:0]       startup_mode_done;
    logic [1:0]       write_mode_done;
    logic [1:0]       busy_startup, busy_write, busy_series;
    logic [OFS_W-1:0] applied [2];
    logic [OFS_W-1:0] measured [2];
    logic [OFS_W-1:0] written [2];

    assign measured[0] = left_measured_offset;
    assign measured[1] = right_measured_offset;
    assign written[0] = left_written_offset_q;
    assign written[1] = right_written_offset_q;

    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        hds_mode_type     st_q, st_d;
        logic [CNT_W-1:0] cnt_q, cnt_d;
        logic [6:0]       rem_q, rem_d;
        logic             sd_q, sd_d, wd_q, wd_d;
        logic [OFS_W-1:0] app_q, app_d;
        logic             t_su, t_wr, t_se;

        always_comb
        begin
            t_su = trig_wr && reg_wdata[POS_STARTUP_TRIG + c];
            t_wr = trig_wr && reg_wdata[POS_WRITE_TRIG + c];
            t_se = trig_wr && reg_wdata[POS_SERIES_TRIG + c];
            st_d = st_q;
            cnt_d = cnt_q;
            rem_d = rem_q;
            sd_d = sd_q;
            wd_d = wd_q;
            app_d = app_q;
            if (st_q == ST_IDLE)
            begin
                cnt_d = CNT_W'(UPDATE_CYCLES - 1);
                if (t_su)
                begin
                    st_d = ST_STARTUP;
                    cnt_d = CNT_W'(STARTUP_CYCLES - 1);
                    sd_d = 1'b0;
                end
                else if (t_wr)
                begin
                    st_d = ST_WRITE;
                    wd_d = 1'b0;
                end
                else if (t_se)
                begin
                    st_d = ST_SERIES;
                    rem_d = series_update_count_q;
                end
                else if (periodic_q)
                begin
                    st_d = ST_SERIES;
                    rem_d = '0;
                end
            end
            else if (cnt_q != '0)
                cnt_d = CNT_W'(cnt_q - CNT_W'(1));
            else
            begin
                st_d = ST_IDLE;
                app_d = measured[c];
                unique case (st_q)
                    ST_STARTUP: sd_d = 1'b1;
                    ST_WRITE:
                    begin
                        app_d = written[c];
                        wd_d = 1'b1;
                    end
                    ST_SERIES:
                    begin
                        if (rem_q != '0)
                        begin
                            st_d = ST_SERIES;
                            rem_d = 7'(rem_q - 7'd1);
                            cnt_d = CNT_W'(UPDATE_CYCLES - 1);
                        end
                    end
                    ST_IDLE: st_d = ST_IDLE;
                endcase
            end
        end

        always_ff @(posedge sys_clk or posedge reset)
        begin
            if (reset)
            begin
                st_q <= ST_IDLE;
                cnt_q <= '0;
                rem_q <= '0;
                sd_q <= 1'b0;
                wd_q <= 1'b0;
                app_q <= OFS_RESET;
            end
            else
            begin
                st_q <= st_d;
                cnt_q <= cnt_d;
                rem_q <= rem_d;
                sd_q <= sd_d;
                wd_q <= wd_d;
                app_q <= app_d;
            end
        end

        assign startup_mode_done[c] = sd_q;
        assign write_mode_done[c] = wd_q;
        assign busy_startup[c] = (st_q == ST_STARTUP);
        assign busy_write[c] = (st_q == ST_WRITE);
        assign busy_series[c] = (st_q == ST_SERIES);
        assign applied[c] = app_q;
    end

    assign left_applied_offset = applied[0];
    assign right_applied_offset = applied[1];

    // Read path, one cycle latency; RO registers have no write decode
    logic [REG_DW-1:0] rdata_q, rdata_d;
    logic              rvalid_q;

    always_comb
    begin
        rdata_d = '0;
        unique case (reg_addr)
            ADDR_TRIGGER:
            begin
                rdata_d[POS_WRITE_TRIG +: 2] = busy_write;
                rdata_d[POS_STARTUP_TRIG +: 2] = busy_startup;
                rdata_d[POS_SERIES_TRIG +: 2] = busy_series | busy_write;
            end
            ADDR_SERIES:
            begin
                rdata_d[POS_SERIES_LO +: 7] = series_update_count_q;
                rdata_d[POS_PERIOD_LO +: 4] = periodic_update_interval_q;
            end
            ADDR_WRITE_OFS: rdata_d = {right_written_offset_q, left_written_offset_q};
            ADDR_FLAGS:
            begin
                rdata_d[POS_ANY_DONE_LO +: 2] = write_mode_done | startup_mode_done;
                rdata_d[POS_WR_DONE_LO +: 2] = write_mode_done;
                rdata_d[POS_SU_DONE_LO +: 2] = startup_mode_done;
            end
            ADDR_RIGHT_RB: rdata_d[OFS_W-1:0] = applied[1];
            ADDR_LEFT_RB: rdata_d[OFS_W-1:0] = applied[0];
            ADDR_HP_ENABLES:
            begin
                rdata_d[POS_SHORT_RMV] = short_rmv_q;
                rdata_d[POS_OUT_STAGE] = out_stage_q;
                rdata_d[POS_MID_STAGE] = mid_stage_q;
            end
            default: rdata_d = '0;
        endcase
        if (!reg_rd)
            rdata_d = rdata_q;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rdata_valid = rvalid_q;
endmodule

/* File: src/hds_pkg.sv */
/*
 Shared constants for the headphone DC servo register bank:
 register addresses, field positions, reset values, mode states, timing.
 Assumes a 16-bit register word reached by an 8-bit register address.
*/
package hds_pkg;
    localparam int          REG_AW            = 8;
    localparam int          REG_DW            = 16;
    localparam int          OFS_W             = 8;
    localparam int          CNT_W             = 16;
    localparam int          TICK_W            = 24;
    localparam int          PER_W             = 16;

    localparam logic [7:0]  ADDR_TRIGGER      = 8'h54;
    localparam logic [7:0]  ADDR_SERIES       = 8'h55;
    localparam logic [7:0]  ADDR_WRITE_OFS    = 8'h57;
    localparam logic [7:0]  ADDR_FLAGS        = 8'h58;
    localparam logic [7:0]  ADDR_RIGHT_RB     = 8'h59;
    localparam logic [7:0]  ADDR_LEFT_RB      = 8'h5A;
    localparam logic [7:0]  ADDR_HP_ENABLES   = 8'h60;

    // Trigger register bit positions, left channel; right is one higher
    localparam int          POS_WRITE_TRIG    = 2;
    localparam int          POS_STARTUP_TRIG  = 4;
    localparam int          POS_SERIES_TRIG   = 8;

    localparam int          POS_SERIES_LO     = 5;
    localparam int          POS_PERIOD_LO     = 0;
    localparam int          POS_RIGHT_WR_LO   = 8;
    localparam int          POS_LEFT_WR_LO    = 0;
    localparam int          POS_ANY_DONE_LO   = 8;
    localparam int          POS_WR_DONE_LO    = 4;
    localparam int          POS_SU_DONE_LO    = 0;
    localparam int          POS_SHORT_RMV     = 7;
    localparam int          POS_OUT_STAGE     = 6;
    localparam int          POS_MID_STAGE     = 5;

    localparam logic [6:0]  SERIES_RESET      = 7'h2A;
    localparam logic [3:0]  PERIOD_RESET      = 4'hA;
    localparam logic [3:0]  PERIOD_OFF        = 4'h0;
    localparam logic [7:0]  OFS_RESET         = 8'h00;

    localparam longint      CLK_PERIOD_NS     = 20;
    localparam longint      TICK_TIME_NS      = 256000000;
    localparam int          TICK_CYCLES_DOC   = int'(TICK_TIME_NS / CLK_PERIOD_NS);
    localparam int          UPDATE_CYCLES_DEF = 64;
    localparam int          STARTUP_CYCLES_DEF = 1024;

    typedef enum logic [1:0] {ST_IDLE, ST_STARTUP, ST_WRITE, ST_SERIES} hds_mode_type;
endpackage

/* File: verification/hds_dc_servo_regs_asserts.sv */
/*
 Port checker for the headphone DC servo register bank.
 Assumes binding onto hds_dc_servo_regs, one clock, async high reset.
*/
`timescale 1ns/100ps
module hds_regs_asserts
(
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [hds_pkg::REG_AW-1:0] reg_addr,
    input wire logic [hds_pkg::REG_DW-1:0] reg_wdata,
    input wire logic [hds_pkg::REG_DW-1:0] reg_rdata,
    input wire logic                       reg_rdata_valid,
    input wire logic [hds_pkg::OFS_W-1:0]  left_applied_offset,
    input wire logic [hds_pkg::OFS_W-1:0]  right_applied_offset,
    input wire logic                       left_short_removal,
    input wire logic                       left_output_stage_on,
    input wire logic                       left_intermediate_stage_on
);
    import hds_pkg::*;
    logic [2:0] stg;
    logic       hp_wr;
    logic       mapped;
    assign stg = {left_short_removal, left_output_stage_on, left_intermediate_stage_on};
    assign hp_wr = reg_wr && (reg_addr == ADDR_HP_ENABLES);
    assign mapped = reg_addr inside {ADDR_TRIGGER, ADDR_SERIES, ADDR_WRITE_OFS, ADDR_FLAGS,
                                     ADDR_RIGHT_RB, ADDR_LEFT_RB, ADDR_HP_ENABLES};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    rd_valid_a: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read strobe without valid");
    valid_cause_a: assert property (!reg_rd |=> !reg_rdata_valid)
        else $error("valid without read strobe");
    rdata_hold_a: assert property (!reg_rdata_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    short_rmv_a: assert property (hp_wr |=> left_short_removal == $past(reg_wdata[7]))
        else $error("short removal not taken from write");
    stage_bits_a: assert property (hp_wr |=> stg[1:0] == $past(reg_wdata[6:5]))
        else $error("stage enables not taken from write");
    stage_hold_a: assert property (!hp_wr |=> $stable(stg))
        else $error("stage enables moved without write");
    stage_read_a: assert property (reg_rd && reg_addr == ADDR_HP_ENABLES
        |=> reg_rdata[7:5] == $past(stg))
        else $error("stage enables read wrong");
    right_rb_a: assert property (reg_rd && reg_addr == ADDR_RIGHT_RB
        |=> reg_rdata == {8'h00, $past(right_applied_offset)})
        else $error("right readback differs from applied");
    left_rb_a: assert property (reg_rd && reg_addr == ADDR_LEFT_RB
        |=> reg_rdata == {8'h00, $past(left_applied_offset)})
        else $error("left readback differs from applied");
    unmapped_rd_a: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    cover property (hp_wr);
    cover property (reg_rd && reg_addr == ADDR_LEFT_RB);
    cover property ($changed(left_applied_offset));
endmodule
bind hds_dc_servo_regs hds_regs_asserts hds_regs_asserts_inst
(
    .sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .left_applied_offset(left_applied_offset),
    .right_applied_offset(right_applied_offset), .left_short_removal(left_short_removal),
    .left_output_stage_on(left_output_stage_on),
    .left_intermediate_stage_on(left_intermediate_stage_on)
);

/* File: verification/hds_host.sv */
/*
 Host model issuing register strobes to the servo register bank.
 Assumes one-cycle strobes sampled at sys_clk rising edge.
*/
`timescale 1ns/100ps
module hds_host
(
    input  wire logic                       sys_clk,
    output logic                            reg_wr,
    output logic                            reg_rd,
    output logic      [hds_pkg::REG_AW-1:0] reg_addr,
    output logic      [hds_pkg::REG_DW-1:0] reg_wdata,
    input  wire logic [hds_pkg::REG_DW-1:0] reg_rdata,
    input  wire logic                       reg_rdata_valid
);
    import hds_pkg::*;
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    // Released address and data are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
        int i;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        for (i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (reg_rdata_valid === 1'b1)
                ok = 1'b1;
            else
                @(posedge sys_clk);
        end
        d = reg_rdata;
    endtask
endmodule

/* File: verification/hds_dc_servo_regs_bench.sv */
/*
 Self-checking bench for the headphone DC servo register bank.
 Assumes shortened tick, update and start-up counts set below.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module hds_dc_servo_regs_bench;
    import hds_pkg::*;
    localparam int UPD = 6;
    logic        sys_clk, reset, reg_wr, reg_rd, reg_rdata_valid;
    logic [7:0]  reg_addr, lmeas, rmeas, lapp, rapp;
    logic [15:0] reg_wdata, reg_rdata;
    logic        shrt, outs, mids;
    int          err_count, n_checks;
    hds_host hds_host_inst (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid));
    hds_dc_servo_regs #(.TICK_CYCLES(8), .UPDATE_CYCLES(UPD), .STARTUP_CYCLES(8))
    hds_dc_servo_regs_inst (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .left_measured_offset(lmeas),
        .right_measured_offset(rmeas), .left_applied_offset(lapp), .right_applied_offset(rapp),
        .left_short_removal(shrt), .left_output_stage_on(outs),
        .left_intermediate_stage_on(mids));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        bit          ok;
        hds_host_inst.rd(a, d, ok);
        if (!ok)
        begin
            err_count++;
            $display("[ERR] read valid exp 1 got 0");
            end_of_test();
        end
        else
            `CHK("reg read", e, d)
    endtask
    task automatic setm(input logic [7:0] l, input logic [7:0] r);
        @(posedge sys_clk);
        lmeas <= l;
        rmeas <= r;
    endtask
    task automatic t_reset();
        rdc(ADDR_SERIES, 16'h054A);
        rdc(ADDR_WRITE_OFS, 16'h0000);
        rdc(ADDR_FLAGS, 16'h0000);
        rdc(ADDR_RIGHT_RB, 16'h0000);
        rdc(ADDR_LEFT_RB, 16'h0000);
        rdc(ADDR_HP_ENABLES, 16'h0000);
        hds_host_inst.wr(ADDR_SERIES, 16'h0FE0);
        rdc(ADDR_SERIES, 16'h0FE0);
        hds_host_inst.wr(8'h70, 16'hFFFF);
        rdc(8'h70, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_write();
        hds_host_inst.wr(ADDR_WRITE_OFS, 16'h807F);
        rdc(ADDR_WRITE_OFS, 16'h807F);
        hds_host_inst.wr(ADDR_TRIGGER, 16'h000C);
        rdc(ADDR_TRIGGER, 16'h030C);
        repeat (UPD + 4) @(posedge sys_clk);
        `CHK("left applied", 8'h7F, lapp)
        `CHK("right applied", 8'h80, rapp)
        rdc(ADDR_FLAGS, 16'h0330);
        rdc(ADDR_RIGHT_RB, 16'h0080);
        rdc(ADDR_LEFT_RB, 16'h007F);
        rdc(ADDR_TRIGGER, 16'h0000);
        hds_host_inst.wr(ADDR_TRIGGER, 16'h0004);
        rdc(ADDR_FLAGS, 16'h0220);
        rdc(ADDR_TRIGGER, 16'h0104);
        repeat (UPD + 4) @(posedge sys_clk);
        rdc(ADDR_FLAGS, 16'h0330);
        $display("write mode test done");
    endtask
    task automatic t_startup();
        setm(8'hE6, 8'h19);
        hds_host_inst.wr(ADDR_TRIGGER, 16'h0030);
        rdc(ADDR_TRIGGER, 16'h0030);
        repeat (12) @(posedge sys_clk);
        `CHK("left applied", 8'hE6, lapp)
        `CHK("right applied", 8'h19, rapp)
        rdc(ADDR_FLAGS, 16'h0333);
        rdc(ADDR_LEFT_RB, 16'h00E6);
        rdc(ADDR_RIGHT_RB, 16'h0019);
        $display("startup test done");
    endtask
    task automatic t_series();
        hds_host_inst.wr(ADDR_SERIES, 16'h0020);
        setm(8'h05, 8'h05);
        hds_host_inst.wr(ADDR_TRIGGER, 16'h0100);
        rdc(ADDR_TRIGGER, 16'h0100);
        repeat (7) @(posedge sys_clk);
        setm(8'h06, 8'h06);
        repeat (4) @(posedge sys_clk);
        rdc(ADDR_TRIGGER, 16'h0000);
        `CHK("left applied", 8'h06, lapp)
        `CHK("right applied", 8'h19, rapp)
        rdc(ADDR_FLAGS, 16'h0333);
        $display("series test done");
    endtask
    task automatic t_periodic();
        setm(8'h2B, 8'hD4);
        hds_host_inst.wr(ADDR_SERIES, 16'h0001);
        repeat (16 + UPD + 6) @(posedge sys_clk);
        `CHK("left periodic", 8'h2B, lapp)
        `CHK("right periodic", 8'hD4, rapp)
        hds_host_inst.wr(ADDR_SERIES, 16'h0000);
        setm(8'h11, 8'h22);
        repeat (60) @(posedge sys_clk);
        `CHK("periodic off", 8'h2B, lapp)
        $display("periodic test done");
    endtask
    task automatic t_stage();
        repeat (1000) @(posedge sys_clk);
        hds_host_inst.wr(ADDR_HP_ENABLES, 16'h0020);
        `CHK("stages", 3'b001, {shrt, outs, mids})
        hds_host_inst.wr(ADDR_HP_ENABLES, 16'h0060);
        `CHK("stages", 3'b011, {shrt, outs, mids})
        hds_host_inst.wr(ADDR_HP_ENABLES, 16'h00E0);
        `CHK("stages", 3'b111, {shrt, outs, mids})
        hds_host_inst.wr(ADDR_FLAGS, 16'hFFFF);
        rdc(ADDR_FLAGS, 16'h0333);
        rdc(ADDR_HP_ENABLES, 16'h00E0);
        $display("stage test done");
    endtask
    initial
    begin
        reset = 1'b1;
        lmeas = 8'h00;
        rmeas = 8'h00;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_write();
        t_startup();
        t_series();
        t_periodic();
        t_stage();
        end_of_test();
    end
endmodule
